// *** rtl/mcos_cfg.svh ***
// Opcode patterns, field positions, reset values and timing counts
`ifndef MCOS_CFG_SVH
`define MCOS_CFG_SVH

// ****************************************************************
// Opcode masks and match values
// ****************************************************************
`define MCOS_IRQ_MASK 16'hfffe
`define MCOS_IRQ_VAL 16'h3592
`define MCOS_STO_MASK 16'hffc0
`define MCOS_STO_VAL 16'h3480
`define MCOS_STOC_MASK 16'hfff8
`define MCOS_STOC_VAL 16'h3550
`define MCOS_STORE_MASK 16'hc003
`define MCOS_STORE_VAL 16'h8001
`define MCOS_STOS_MASK 16'hffc0
`define MCOS_STOS_VAL 16'h3440
`define MCOS_SLEW_MASK 16'hfffe
`define MCOS_SLEW_VAL 16'h3596
`define MCOS_SRB_MASK 16'hffe0
`define MCOS_SRB_VAL 16'h3700

// ****************************************************************
// Operand fields
// ****************************************************************
`define MCOS_LEVEL_BIT 0
`define MCOS_SEL_HI 5
`define MCOS_SEL_LO 2
`define MCOS_STATE_HI 1
`define MCOS_STATE_LO 0
`define MCOS_CTRL_BIT 2
`define MCOS_TGT_HI 1
`define MCOS_TGT_LO 0
`define MCOS_OFS_BIT 13
`define MCOS_SRC_HI 12
`define MCOS_SRC_LO 8
`define MCOS_ADDR_HI 7
`define MCOS_ADDR_LO 2
`define MCOS_SC1_HI 5
`define MCOS_SC1_LO 4
`define MCOS_SC2_HI 3
`define MCOS_SC2_LO 2
`define MCOS_SC3_HI 1
`define MCOS_SC3_LO 0
`define MCOS_SRB_LVL_BIT 4
`define MCOS_SRB_IDX_HI 3
`define MCOS_SRB_IDX_LO 0

// ****************************************************************
// Select codes, state codes, reset values, timing
// ****************************************************************
`define MCOS_SEL_UNDEF 4'hc
`define MCOS_ST_KEEP 2'h0
`define MCOS_ST_OFF 2'h1
`define MCOS_ST_ON 2'h2
`define MCOS_ST_TOGGLE 2'h3
`define MCOS_IRQ_RST 1'h1
`define MCOS_COMP_RST 4'h0
`define MCOS_SLEW_RST 1'h0
`define MCOS_STATUS_RST 16'h0000
`define MCOS_OUT_RST 12'h000
`define MCOS_SLEW_UP_CYC 3'h1
`define MCOS_SLEW_DN_CYC 3'h4

`endif

// *** rtl/mcos_pkg.sv ***
// Types shared by the output and store instruction group
package mcos_pkg;

	typedef enum logic [2:0] {
		mcos_op_none,
		mcos_op_irq,
		mcos_op_sto,
		mcos_op_stoc,
		mcos_op_store,
		mcos_op_stos,
		mcos_op_slew,
		mcos_op_srb
	} mcos_op_t;

	typedef logic [1:0] mcos_state_t;

endpackage

// *** rtl/mcos_dram_if.sv ***
// Data RAM port bundle between the decoder and the RAM
`timescale 1ns/1ns
interface mcos_dram_if #(
	parameter int AW = 6,
	parameter int DW = 16
);
	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [DW-1:0] wr_data;
	logic [AW-1:0] rd_addr;
	logic [DW-1:0] rd_data;

	modport ctrl (
		output wr_en,
		output wr_addr,
		output wr_data,
		output rd_addr,
		input rd_data
	);
	modport mem (
		input wr_en,
		input wr_addr,
		input wr_data,
		input rd_addr,
		output rd_data
	);
endinterface

// *** rtl/mcos_dram.sv ***
// Single-port-write, registered-read data RAM
`timescale 1ns/1ns
module mcos_dram #(
	parameter int AW = 6,
	parameter int DW = 16
) (
	// Clock
	input wire logic clk,
	// RAM port
	mcos_dram_if.mem port
);

	logic [DW-1:0] mem [2**AW];

	always_ff @(posedge clk) begin
		if (port.wr_en) begin
			mem[port.wr_addr] <= port.wr_data;
		end
	end

	// Read data always registered; a write to the same line shows next cycle
	always_ff @(posedge clk) begin
		port.rd_data <= mem[port.rd_addr];
	end

endmodule

// *** rtl/mcos_top.sv ***
// Decoder and executor for the output, compensation and store instructions
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ns
`include "mcos_cfg.svh"
module mcos_top #(
	parameter int NOUT = 12,
	parameter int AW = 6,
	parameter int DW = 16,
	parameter int SRCW = 5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Instruction from the sequencer
	input wire logic instr_valid,
	input wire logic [15:0] instr,
	// Access configuration
	input wire logic [NOUT-1:0] output_access_config,
	input wire logic [3:0] cur_block_access,
	// Shortcut assignment and indexed base
	input wire logic [3:0] shortcut1_sel,
	input wire logic [3:0] shortcut2_sel,
	input wire logic [3:0] shortcut3_sel,
	input wire logic [AW-1:0] addr_base,
	// Source register read
	output logic [SRCW-1:0] src_idx,
	input wire logic [DW-1:0] src_data,
	// Data RAM read port for the rest of the core
	input wire logic [AW-1:0] dram_rd_addr,
	output logic [DW-1:0] dram_rd_data,
	// Controlled outputs
	output logic interrupt_request_pin,
	output logic [NOUT-1:0] pre_drv_out,
	output logic [3:0] comp_en,
	output logic slew_mode_bit,
	output logic slew_fast_eff,
	output logic [15:0] status_reg,
	output logic store_busy
);

	// ****************************************************************
	// Functions
	// ****************************************************************
	function automatic mcos_pkg::mcos_op_t decode(input logic [15:0] w);
		mcos_pkg::mcos_op_t op;
		op = mcos_pkg::mcos_op_none;
		if ((w & `MCOS_IRQ_MASK) == `MCOS_IRQ_VAL) begin
			op = mcos_pkg::mcos_op_irq;
		end else if ((w & `MCOS_STO_MASK) == `MCOS_STO_VAL) begin
			op = mcos_pkg::mcos_op_sto;
		end else if ((w & `MCOS_STOC_MASK) == `MCOS_STOC_VAL) begin
			op = mcos_pkg::mcos_op_stoc;
		end else if ((w & `MCOS_STORE_MASK) == `MCOS_STORE_VAL) begin
			op = mcos_pkg::mcos_op_store;
		end else if ((w & `MCOS_STOS_MASK) == `MCOS_STOS_VAL) begin
			op = mcos_pkg::mcos_op_stos;
		end else if ((w & `MCOS_SLEW_MASK) == `MCOS_SLEW_VAL) begin
			op = mcos_pkg::mcos_op_slew;
		end else if ((w & `MCOS_SRB_MASK) == `MCOS_SRB_VAL) begin
			op = mcos_pkg::mcos_op_srb;
		end
		return op;
	endfunction

	// New level of one output under a two-bit state code
	function automatic logic apply_state(input logic cur,
			input mcos_pkg::mcos_state_t st);
		logic r;
		r = cur;
		unique case (st)
			`MCOS_ST_KEEP: r = cur;
			`MCOS_ST_OFF: r = 1'b0;
			`MCOS_ST_ON: r = 1'b1;
			`MCOS_ST_TOGGLE: r = ~cur;
		endcase
		return r;
	endfunction

	// One-hot mask of a writable output, empty for the undefined codes
	function automatic logic [NOUT-1:0] sel_mask(input logic [3:0] sel,
			input logic [NOUT-1:0] acc);
		logic [NOUT-1:0] m;
		m = '0;
		if (sel < `MCOS_SEL_UNDEF) begin
			m[sel] = 1'b1;
		end
		return m & acc;
	endfunction

	// ****************************************************************
	// Decode
	// ****************************************************************
	mcos_pkg::mcos_op_t op;
	logic [3:0] out_sel;
	mcos_pkg::mcos_state_t out_state;
	logic [1:0] comp_target_field;
	logic comp_ctrl;
	logic next_slew;
	logic [3:0] status_bit_index;
	logic status_level;
	logic slew_allowed;

	always_comb begin
		op = instr_valid ? decode(instr) : mcos_pkg::mcos_op_none;
		out_sel = instr[`MCOS_SEL_HI:`MCOS_SEL_LO];
		out_state = instr[`MCOS_STATE_HI:`MCOS_STATE_LO];
		comp_target_field = instr[`MCOS_TGT_HI:`MCOS_TGT_LO];
		comp_ctrl = instr[`MCOS_CTRL_BIT];
		next_slew = instr[`MCOS_LEVEL_BIT];
		status_bit_index = instr[`MCOS_SRB_IDX_HI:`MCOS_SRB_IDX_LO];
		status_level = instr[`MCOS_SRB_LVL_BIT];
		// Slew affects every output, so any granted drive right is enough
		slew_allowed = |output_access_config;
	end

	// ****************************************************************
	// Interrupt request pin
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			interrupt_request_pin <= `MCOS_IRQ_RST;
		end else if (op == mcos_pkg::mcos_op_irq) begin
			interrupt_request_pin <= instr[`MCOS_LEVEL_BIT];
		end
	end

	// ****************************************************************
	// Pre-driver outputs
	// ****************************************************************
	logic [NOUT-1:0] next_out;
	logic [NOUT-1:0] m1;
	logic [NOUT-1:0] m2;
	logic [NOUT-1:0] m3;

	// Shortcuts applied in order, so a repeated shortcut sees the
	// previous one's result, as if the three were issued back to back
	always_comb begin
		next_out = pre_drv_out;
		m1 = sel_mask(out_sel, output_access_config);
		m2 = '0;
		m3 = '0;
		if (op == mcos_pkg::mcos_op_sto) begin
			for (int i = 0; i < NOUT; i++) begin
				if (m1[i]) begin
					next_out[i] = apply_state(pre_drv_out[i], out_state);
				end
			end
		end else if (op == mcos_pkg::mcos_op_stos) begin
			m1 = sel_mask(shortcut1_sel, output_access_config);
			m2 = sel_mask(shortcut2_sel, output_access_config);
			m3 = sel_mask(shortcut3_sel, output_access_config);
			for (int i = 0; i < NOUT; i++) begin
				if (m1[i]) begin
					next_out[i] = apply_state(next_out[i],
						instr[`MCOS_SC1_HI:`MCOS_SC1_LO]);
				end
				if (m2[i]) begin
					next_out[i] = apply_state(next_out[i],
						instr[`MCOS_SC2_HI:`MCOS_SC2_LO]);
				end
				if (m3[i]) begin
					next_out[i] = apply_state(next_out[i],
						instr[`MCOS_SC3_HI:`MCOS_SC3_LO]);
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pre_drv_out <= `MCOS_OUT_RST;
		end else begin
			pre_drv_out <= next_out;
		end
	end

	// ****************************************************************
	// Offset compensation
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			comp_en <= `MCOS_COMP_RST;
		end else if (op == mcos_pkg::mcos_op_stoc &&
				cur_block_access[comp_target_field]) begin
			comp_en[comp_target_field] <= comp_ctrl;
		end
	end

	// ****************************************************************
	// Slew rate mode
	// ****************************************************************
	logic [2:0] slew_cnt;

	always_ff @(posedge clk) begin
		if (rst) begin
			slew_mode_bit <= `MCOS_SLEW_RST;
		end else if (op == mcos_pkg::mcos_op_slew && slew_allowed) begin
			slew_mode_bit <= next_slew;
		end
	end

	// The driver stages need longer to settle when slowing down, so the
	// effective mode lags the commanded one by a direction-dependent count
	always_ff @(posedge clk) begin
		if (rst) begin
			slew_cnt <= 3'h0;
		end else if (op == mcos_pkg::mcos_op_slew && slew_allowed &&
				next_slew != slew_mode_bit) begin
			slew_cnt <= next_slew ? `MCOS_SLEW_UP_CYC
				: `MCOS_SLEW_DN_CYC;
		end else if (slew_cnt != 3'h0) begin
			slew_cnt <= slew_cnt - 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			slew_fast_eff <= `MCOS_SLEW_RST;
		end else if (slew_cnt == 3'h1) begin
			slew_fast_eff <= slew_mode_bit;
		end
	end

	// ****************************************************************
	// Status register bit
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			status_reg <= `MCOS_STATUS_RST;
		end else if (op == mcos_pkg::mcos_op_srb) begin
			status_reg[status_bit_index] <= status_level;
		end
	end

	// ****************************************************************
	// Data RAM store
	// ****************************************************************
	// The register file answers in the same cycle the index is presented,
	// so the write lands in the cycle after the instruction is taken
	mcos_dram_if #(.AW(AW), .DW(DW)) dram ();
	logic [AW-1:0] store_addr;

	always_ff @(posedge clk) begin
		if (rst) begin
			store_busy <= 1'b0;
		end else begin
			store_busy <= (op == mcos_pkg::mcos_op_store);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			src_idx <= '0;
			store_addr <= '0;
		end else if (op == mcos_pkg::mcos_op_store) begin
			src_idx <= instr[`MCOS_SRC_HI:`MCOS_SRC_LO];
			if (instr[`MCOS_OFS_BIT]) begin
				// Indexed address wraps inside the RAM
				store_addr <= AW'(addr_base +
					instr[`MCOS_ADDR_HI:`MCOS_ADDR_LO]);
			end else begin
				store_addr <= instr[`MCOS_ADDR_HI:`MCOS_ADDR_LO];
			end
		end
	end

	always_comb begin
		dram.wr_en = store_busy;
		dram.wr_addr = store_addr;
		dram.wr_data = src_data;
		dram.rd_addr = dram_rd_addr;
		dram_rd_data = dram.rd_data;
	end

	mcos_dram #(.AW(AW), .DW(DW)) u_dram (
		.clk(clk),
		.port(dram.mem)
	);

endmodule

// *** verif/mcos_reg_model.sv ***
// Register file stand-in that answers the store source read
`timescale 1ns/1ns
module mcos_reg_model (
	// Source register read
	input wire logic [4:0] src_idx,
	output logic [15:0] src_data
);
	// A value unique to each index, so a wrong index shows in the RAM
	assign src_data = {~src_idx, 11'h5a3};
endmodule

// *** verif/mcos_top_properties.sv ***
// Concurrent checks on the ports of the instruction group
`timescale 1ns/1ns
module mcos_top_checker #(
	parameter int NOUT = 12,
	parameter int SRCW = 5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Instruction and rights
	input wire logic instr_valid,
	input wire logic [15:0] instr,
	input wire logic [NOUT-1:0] output_access_config,
	input wire logic [3:0] cur_block_access,
	// Observed state
	input wire logic [SRCW-1:0] src_idx,
	input wire logic interrupt_request_pin,
	input wire logic [NOUT-1:0] pre_drv_out,
	input wire logic [3:0] comp_en,
	input wire logic slew_mode_bit,
	input wire logic slew_fast_eff,
	input wire logic [15:0] status_reg,
	input wire logic store_busy
);
	logic is_irq, is_sto, is_stoc, is_st, is_slew, is_srb, sto_new;
	logic [3:0] sel;
	assign is_irq = instr_valid && instr[15:1] == 15'h1ac9;
	assign is_sto = instr_valid && instr[15:6] == 10'h0d2;
	assign is_stoc = instr_valid && instr[15:3] == 13'h06aa;
	assign is_st = instr_valid && instr[15:14] == 2'h2 && instr[1:0] == 2'h1;
	assign is_slew = instr_valid && instr[15:1] == 15'h1acb;
	assign is_srb = instr_valid && instr[15:5] == 11'h1b8;
	assign sel = instr[5:2];
	assign sto_new = (instr[1] ^ instr[0]) ? instr[1]
		: pre_drv_out[sel] ^ instr[0];
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_irq;
		is_irq |=> interrupt_request_pin == $past(instr[0]);
	endproperty
	a_irq: assert property (p_irq) else $error("irq level");
	property p_rst;
		$fell(rst) |-> interrupt_request_pin && comp_en == 4'h0 && !slew_mode_bit;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_sto;
		is_sto && sel < 4'hc && output_access_config[sel]
			|=> pre_drv_out[$past(sel)] == $past(sto_new);
	endproperty
	a_sto: assert property (p_sto) else $error("single output");
	property p_sto_deny;
		is_sto && (sel >= 4'hc || !output_access_config[sel])
			|=> $stable(pre_drv_out);
	endproperty
	a_sto_deny: assert property (p_sto_deny)
		else $error("output moved");
	property p_stoc;
		is_stoc && cur_block_access[instr[1:0]]
			|=> comp_en[$past(instr[1:0])] == $past(instr[2]);
	endproperty
	a_stoc: assert property (p_stoc) else $error("compensation");
	property p_stoc_deny;
		is_stoc && !cur_block_access[instr[1:0]] |=> $stable(comp_en);
	endproperty
	a_stoc_deny: assert property (p_stoc_deny)
		else $error("comp moved");
	property p_store;
		is_st |=> store_busy && src_idx == $past(instr[12:8]);
	endproperty
	a_store: assert property (p_store) else $error("store source");
	property p_slew;
		is_slew |=> slew_mode_bit == (($past(output_access_config) != '0) ?
			$past(instr[0]) : $past(slew_mode_bit));
	endproperty
	a_slew: assert property (p_slew) else $error("slew mode");
	property p_slew_up;
		$rose(slew_mode_bit) && !$past(rst) |=> slew_fast_eff;
	endproperty
	a_slew_up: assert property (p_slew_up) else $error("slew up");
	// Only a countdown left alone is judged: a reversal reloads it.
	// The effective bit can only fall while slow is commanded, so a
	// high value on the last counted cycle covers the earlier ones.
	property p_slew_dn;
		($fell(slew_mode_bit) && !$past(rst)) ##1 (!slew_mode_bit)[*3]
			|-> slew_fast_eff ##1 (!slew_fast_eff || slew_mode_bit);
	endproperty
	a_slew_dn: assert property (p_slew_dn) else $error("slew down");
	property p_srb;
		is_srb |=> status_reg[$past(instr[3:0])] == $past(instr[4]);
	endproperty
	a_srb: assert property (p_srb) else $error("status bit");
	c_store: cover property (is_st ##1 is_st);
	c_slew_dn: cover property ($fell(slew_mode_bit));
	c_stoc_deny: cover property (is_stoc && !cur_block_access[instr[1:0]]);
endmodule

bind mcos_top mcos_top_checker #(.NOUT(NOUT), .SRCW(SRCW)) u_chk (
	.clk, .rst, .instr_valid, .instr, .output_access_config,
	.cur_block_access, .src_idx, .interrupt_request_pin, .pre_drv_out,
	.comp_en, .slew_mode_bit, .slew_fast_eff, .status_reg, .store_busy
);

// *** verif/microcore_output_store_ops_test.sv ***
// Self-checking bench for the output and store instruction group
`timescale 1ns/1ns
module microcore_output_store_ops_test;
	typedef struct {
		logic [15:0] ins;
		logic [11:0] oac;
		logic [3:0] cba;
		logic [11:0] pre;
		logic [3:0] comp;
		logic irq;
	} mcos_row_t;
	mcos_row_t rows[20];
	logic clk = 1'b0, rst = 1'b1, instr_valid = 1'b0;
	logic [15:0] instr = 16'h0000;
	logic [11:0] oac = 12'hfff;
	logic [3:0] cba = 4'hf;
	logic [3:0] shortcut1_sel = 4'h0, shortcut2_sel = 4'h5, shortcut3_sel = 4'hb;
	logic [5:0] addr_base = 6'h00, dram_rd_addr = 6'h00;
	logic [4:0] src_idx;
	logic [15:0] src_data, dram_rd_data, status_reg;
	logic [11:0] pre_drv_out;
	logic [3:0] comp_en;
	logic interrupt_request_pin, slew_mode_bit, slew_fast_eff, store_busy;
	int error_cnt = 0;
	int tests_run = 0;

	always #5 clk = ~clk;

	mcos_top u_mcos_top (
		.clk, .rst, .instr_valid, .instr, .output_access_config(oac),
		.cur_block_access(cba), .shortcut1_sel, .shortcut2_sel,
		.shortcut3_sel, .addr_base, .src_idx, .src_data, .dram_rd_addr,
		.dram_rd_data, .interrupt_request_pin, .pre_drv_out, .comp_en,
		.slew_mode_bit, .slew_fast_eff, .status_reg, .store_busy
	);
	mcos_reg_model u_mcos_reg_model (.src_idx, .src_data);

	task check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task step(input logic [15:0] ins);
		@(posedge clk);
		#1 instr_valid = 1'b1;
		instr = ins;
		@(posedge clk);
		#1 instr_valid = 1'b0;
	endtask

	task do_reset;
		@(posedge clk);
		#1 rst = 1'b1;
		repeat (8) @(posedge clk);
		#1 rst = 1'b0;
		check({15'h0, interrupt_request_pin}, 16'h0001);
		check({4'h0, pre_drv_out}, 16'h0000);
		check({12'h0, comp_en}, 16'h0000);
		check({14'h0, slew_mode_bit, slew_fast_eff}, 16'h0000);
		check(status_reg, 16'h0000);
	endtask

	task stop_test;
		$display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// A hang ends the run as a failure
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		stop_test();
	end

	initial begin
		rows = '{
			'{16'h3592, 12'hfff, 4'hf, 12'h000, 4'h0, 1'h0},
			'{16'h3593, 12'hfff, 4'hf, 12'h000, 4'h0, 1'h1},
			'{16'h3482, 12'hfff, 4'hf, 12'h001, 4'h0, 1'h1},
			'{16'h34ae, 12'hfff, 4'hf, 12'h801, 4'h0, 1'h1},
			'{16'h3483, 12'hfff, 4'hf, 12'h800, 4'h0, 1'h1},
			'{16'h34ad, 12'hfff, 4'hf, 12'h000, 4'h0, 1'h1},
			'{16'h3493, 12'hfff, 4'hf, 12'h010, 4'h0, 1'h1},
			'{16'h3490, 12'hfff, 4'hf, 12'h010, 4'h0, 1'h1},
			'{16'h34b2, 12'hfff, 4'hf, 12'h010, 4'h0, 1'h1},
			'{16'h34be, 12'hfff, 4'hf, 12'h010, 4'h0, 1'h1},
			'{16'h3491, 12'hfef, 4'hf, 12'h010, 4'h0, 1'h1},
			'{16'h346a, 12'hfff, 4'hf, 12'h831, 4'h0, 1'h1},
			'{16'h3453, 12'hfff, 4'hf, 12'h030, 4'h0, 1'h1},
			'{16'h3465, 12'hffe, 4'hf, 12'h010, 4'h0, 1'h1},
			'{16'h3554, 12'hfff, 4'hf, 12'h010, 4'h1, 1'h1},
			'{16'h3557, 12'hfff, 4'hf, 12'h010, 4'h9, 1'h1},
			'{16'h3556, 12'hfff, 4'h7, 12'h010, 4'hd, 1'h1},
			'{16'h3553, 12'hfff, 4'h7, 12'h010, 4'hd, 1'h1},
			'{16'h3550, 12'hfff, 4'h7, 12'h010, 4'hc, 1'h1},
			'{16'h3594, 12'hfff, 4'hf, 12'h010, 4'hc, 1'h1}
		};
		do_reset();
		foreach (rows[i]) begin
			oac = rows[i].oac;
			cba = rows[i].cba;
			step(rows[i].ins);
			check(16'(pre_drv_out), 16'(rows[i].pre));
			check({12'h0, comp_en}, {12'h0, rows[i].comp});
			check({15'h0, interrupt_request_pin}, {15'h0, rows[i].irq});
		end
		for (int i = 0; i < 16; i++) begin
			step(16'h3710 | 16'(i));
			check(status_reg, 16'hffff >> (15 - i));
		end
		step(16'h3705);
		check(status_reg, 16'hffdf);
		oac = 12'h000;
		step(16'h3597);
		check({14'h0, slew_mode_bit, slew_fast_eff}, 16'h0000);
		oac = 12'h800;
		step(16'h3597);
		check({14'h0, slew_mode_bit, slew_fast_eff}, 16'h0002);
		@(posedge clk);
		#1 check({14'h0, slew_mode_bit, slew_fast_eff}, 16'h0003);
		step(16'h3596);
		for (int k = 0; k < 5; k++) begin
			check({14'h0, slew_mode_bit, slew_fast_eff}, {15'h0, k < 4});
			@(posedge clk);
			#1;
		end
		// Two stores back to back: immediate, then indexed with wrap
		addr_base = 6'h3e;
		@(posedge clk);
		#1 instr_valid = 1'b1;
		instr = 16'h8315;
		@(posedge clk);
		#1 instr = 16'ha70d;
		check({11'h0, src_idx}, 16'h0003);
		check({15'h0, store_busy}, 16'h0001);
		@(posedge clk);
		#1 instr_valid = 1'b0;
		dram_rd_addr = 6'h05;
		check({11'h0, src_idx}, 16'h0007);
		@(posedge clk);
		#1 dram_rd_addr = 6'h01;
		check(dram_rd_data, 16'he5a3);
		check({15'h0, store_busy}, 16'h0000);
		@(posedge clk);
		#1 check(dram_rd_data, 16'hc5a3);
		// Pin low and fast mode on, so the second reset has work to undo
		step(16'h3592);
		step(16'h3597);
		check({15'h0, interrupt_request_pin}, 16'h0000);
		check({14'h0, slew_mode_bit, slew_fast_eff}, 16'h0002);
		do_reset();
		// Let the checker see the release as well
		repeat (2) @(posedge clk);
		stop_test();
	end
endmodule
